// ---- hdl/sdcr_pkg.sv ----
// Constants for the synthesizer divider configuration register bank
// ================================================================
// Notes on behaviour
// - Bit 14 of word 0x1F enables the first divide-by-two of the channel divider.
// - Feedback divider is 19 bits: 0x22 bits 2:0 on top, 0x24 below.
// - Word 0x25 bits 13:8 hold the phase detector delay chosen by software.
// - Denominator is 32 bits: 0x26 upper half, 0x27 lower; each resets 0xFFFF.
// - Word 0x28 holds the upper half of the modulator seed.
// - Word 0x29 holds the lower half of the modulator seed.
// - Order 0 is integer mode, 1 to 3 modulator orders, others unused.
package sdcr_pkg;

    // ================================================================
    // Sizes
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_WORDS = 14;
    localparam int FBDIV_W = 19;
    localparam int PDD_W = 6;
    localparam int ORDER_W = 3;

    // ================================================================
    // Word indices and offsets
    localparam int IDX_CHAN_DIV = 2;
    localparam int IDX_FBDIV_HI = 5;
    localparam int IDX_FBDIV_LO = 7;
    localparam int IDX_PDD = 8;
    localparam int IDX_DEN_HI = 9;
    localparam int IDX_DEN_LO = 10;
    localparam int IDX_SEED_HI = 11;
    localparam int IDX_SEED_LO = 12;
    localparam int IDX_MOD_CTRL = 13;

    localparam logic [ADDR_W-1:0] OFF_RESV_1D = 8'h1D;
    localparam logic [ADDR_W-1:0] OFF_CHAN_DIV = 8'h1F;
    localparam logic [ADDR_W-1:0] OFF_FBDIV_HI = 8'h22;
    localparam logic [ADDR_W-1:0] OFF_FBDIV_LO = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_PDD = 8'h25;
    localparam logic [ADDR_W-1:0] OFF_DEN_HI = 8'h26;
    localparam logic [ADDR_W-1:0] OFF_DEN_LO = 8'h27;
    localparam logic [ADDR_W-1:0] OFF_SEED_HI = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_SEED_LO = 8'h29;
    localparam logic [ADDR_W-1:0] OFF_MOD_CTRL = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h3F;

    localparam logic [ADDR_W-1:0] WORD_OFFSET [NUM_WORDS] = '{
        8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23,
        8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2C};

    // ================================================================
    // Reset values, writable bits, mandated reserved values and their masks
    localparam logic [DATA_W-1:0] WORD_RESET [NUM_WORDS] = '{
        16'h318C, 16'h318C, 16'hC3EC, 16'h0393, 16'h1E21, 16'h0010, 16'h0004,
        16'h0070, 16'h0205, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0002};
    localparam logic [DATA_W-1:0] WORD_WMASK [NUM_WORDS] = '{
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0007};
    localparam logic [DATA_W-1:0] RESV_VALUE [NUM_WORDS] = '{
        16'h318C, 16'h318C, 16'h03EC, 16'h0393, 16'h1E21, 16'h0000, 16'h0004,
        16'h0000, 16'h8004, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [DATA_W-1:0] RESV_MASK [NUM_WORDS] = '{
        16'hFFFF, 16'hFFFF, 16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFF8, 16'hFFFF,
        16'h0000, 16'hC0FF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // ================================================================
    // Field positions
    localparam int HALVER_BIT = 14;
    localparam int PDD_LSB = 8;
    localparam int STATUS_ORDER_BIT = 13;
    localparam logic [ORDER_W-1:0] ORDER_MAX = 3'h3;

    typedef enum logic [2:0] {
        SDCR_MODE_INTEGER,
        SDCR_MODE_FIRST,
        SDCR_MODE_SECOND,
        SDCR_MODE_THIRD,
        SDCR_MODE_UNUSED
    } sdcr_mode_t;

endpackage

// ---- hdl/sdcr_word.sv ----
// One 16-bit configuration word with reset value and writable-bit mask
`timescale 1ns/10ps
module sdcr_word #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] word_o
);

    // ================================================================
    // Storage
    // Bits outside the mask hold their reset value and read back as such
    logic [15:0] next_word;

    assign next_word = (word_o & ~WMASK) | (wdata_i & WMASK);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            word_o <= RESET_VAL;
        end
        else if (wr_en_i)
        begin
            word_o <= next_word;
        end
    end

endmodule

// ---- hdl/sdcr_regs.sv ----
// Divider, denominator, seed and modulator order configuration bank
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module sdcr_regs (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [sdcr_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [sdcr_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [sdcr_pkg::DATA_W-1:0] reg_rdata_o,
    output logic first_halver_enable_o,
    output logic [sdcr_pkg::FBDIV_W-1:0] feedback_div_o,
    output logic [sdcr_pkg::PDD_W-1:0] phase_det_delay_o,
    output logic [31:0] frac_denominator_o,
    output logic [31:0] modulator_seed_o,
    output logic [sdcr_pkg::ORDER_W-1:0] modulator_order_o,
    output sdcr_pkg::sdcr_mode_t modulator_mode_o,
    output logic integer_mode_o,
    output logic reserved_fault_o
);

    // ================================================================
    // Storage and address decode
    logic [sdcr_pkg::DATA_W-1:0] word_q [sdcr_pkg::NUM_WORDS];
    logic [sdcr_pkg::NUM_WORDS-1:0] word_hit;
    logic [sdcr_pkg::NUM_WORDS-1:0] word_wr;
    logic [sdcr_pkg::NUM_WORDS-1:0] resv_bad;
    logic [sdcr_pkg::DATA_W-1:0] hit_data [sdcr_pkg::NUM_WORDS];
    logic status_hit;
    logic order_unused;
    logic [sdcr_pkg::DATA_W-1:0] status_word;
    logic [sdcr_pkg::DATA_W-1:0] rd_sel;
    logic [sdcr_pkg::DATA_W-1:0] next_rdata;

    genvar g;
    generate
        for (g = 0; g < sdcr_pkg::NUM_WORDS; g = g + 1)
        begin : gen_word
            assign word_hit[g] = (reg_addr_i == sdcr_pkg::WORD_OFFSET[g]);
            assign word_wr[g] = reg_wr_i & word_hit[g];
            assign hit_data[g] = word_hit[g] ? word_q[g] : 16'h0000;
            // Reserved fields compared to their mandated values
            assign resv_bad[g] = |((word_q[g] ^ sdcr_pkg::RESV_VALUE[g])
                & sdcr_pkg::RESV_MASK[g]);

            sdcr_word #(
                .RESET_VAL(sdcr_pkg::WORD_RESET[g]),
                .WMASK(sdcr_pkg::WORD_WMASK[g])
            ) u_word (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .wr_en_i(word_wr[g]),
                .wdata_i(reg_wdata_i),
                .word_o(word_q[g])
            );
        end
    endgenerate

    assign status_hit = (reg_addr_i == sdcr_pkg::OFF_STATUS);

    // ================================================================
    // Decoded fields
    // Split values are presented whole so no consumer stitches halves
    assign first_halver_enable_o = word_q[sdcr_pkg::IDX_CHAN_DIV][sdcr_pkg::HALVER_BIT];
    assign feedback_div_o = {word_q[sdcr_pkg::IDX_FBDIV_HI][2:0],
        word_q[sdcr_pkg::IDX_FBDIV_LO]};
    assign phase_det_delay_o =
        word_q[sdcr_pkg::IDX_PDD][sdcr_pkg::PDD_LSB +: sdcr_pkg::PDD_W];
    assign frac_denominator_o = {word_q[sdcr_pkg::IDX_DEN_HI],
        word_q[sdcr_pkg::IDX_DEN_LO]};
    assign modulator_seed_o = {word_q[sdcr_pkg::IDX_SEED_HI],
        word_q[sdcr_pkg::IDX_SEED_LO]};
    assign modulator_order_o = word_q[sdcr_pkg::IDX_MOD_CTRL][sdcr_pkg::ORDER_W-1:0];

    // ================================================================
    // Modulator mode
    // Unused codes are flagged, never folded onto a legal order
    assign order_unused = (modulator_order_o > sdcr_pkg::ORDER_MAX);
    assign integer_mode_o = (modulator_order_o == 3'h0);

    always_comb
    begin
        case (modulator_order_o)
            3'h0: modulator_mode_o = sdcr_pkg::SDCR_MODE_INTEGER;
            3'h1: modulator_mode_o = sdcr_pkg::SDCR_MODE_FIRST;
            3'h2: modulator_mode_o = sdcr_pkg::SDCR_MODE_SECOND;
            3'h3: modulator_mode_o = sdcr_pkg::SDCR_MODE_THIRD;
            default: modulator_mode_o = sdcr_pkg::SDCR_MODE_UNUSED;
        endcase
    end

    // ================================================================
    // Status
    assign status_word = {2'b00, order_unused, resv_bad[sdcr_pkg::NUM_WORDS-2:0]};
    assign reserved_fault_o = |resv_bad;

    // ================================================================
    // Read path
    // Unmapped reads return zero; data stands one cycle only
    always_comb
    begin
        rd_sel = status_hit ? status_word : 16'h0000;
        for (int i = 0; i < sdcr_pkg::NUM_WORDS; i++)
        begin
            rd_sel = rd_sel | hit_data[i];
        end
    end

    assign next_rdata = reg_rd_i ? rd_sel : 16'h0000;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 16'h0000;
        end
        else
        begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wr(logic [7:0] off);
        reg_wr_i && (reg_addr_i == off);
    endsequence

    sequence s_rd(logic [7:0] off);
        reg_rd_i && (reg_addr_i == off);
    endsequence

    AST_RESV_1D_FLAG: assert property (
        s_wr(sdcr_pkg::OFF_RESV_1D) ##0 (reg_wdata_i != 16'h318C)
        |=> resv_bad[0] && reserved_fault_o)
        else $error("word 0x1D bad value not flagged");

    AST_HALVER: assert property (
        s_wr(sdcr_pkg::OFF_CHAN_DIV)
        |=> first_halver_enable_o == $past(reg_wdata_i[14]))
        else $error("halver enable not taken from bit 14");

    AST_CHAN_DIV_RESV: assert property (
        s_wr(sdcr_pkg::OFF_CHAN_DIV) ##0 (reg_wdata_i[15] == 1'b1)
        |=> resv_bad[sdcr_pkg::IDX_CHAN_DIV])
        else $error("word 0x1F bit 15 set not flagged");

    AST_FBDIV_LO: assert property (
        s_wr(sdcr_pkg::OFF_FBDIV_LO)
        |=> feedback_div_o[15:0] == $past(reg_wdata_i)
            && $stable(feedback_div_o[18:16]))
        else $error("feedback divider low half wrong");

    AST_FBDIV_HI: assert property (
        s_wr(sdcr_pkg::OFF_FBDIV_HI)
        |=> feedback_div_o[18:16] == $past(reg_wdata_i[2:0]))
        else $error("feedback divider high bits wrong");

    AST_FBDIV_RESV: assert property (
        s_wr(sdcr_pkg::OFF_FBDIV_HI) ##0 (reg_wdata_i[15:3] == 13'h0000)
        |=> !resv_bad[sdcr_pkg::IDX_FBDIV_HI])
        else $error("word 0x22 clean value flagged");

    AST_PDD: assert property (
        s_wr(sdcr_pkg::OFF_PDD)
        |=> phase_det_delay_o == $past(reg_wdata_i[13:8]))
        else $error("phase detector delay wrong");

    AST_PDD_RESV: assert property (
        s_wr(sdcr_pkg::OFF_PDD) ##0 (reg_wdata_i[15:14] == 2'h2)
            ##0 (reg_wdata_i[7:0] == 8'h04)
        |=> !resv_bad[sdcr_pkg::IDX_PDD])
        else $error("word 0x25 clean value flagged");

    AST_DEN_RESET: assert property (
        $fell(rst_i) |-> frac_denominator_o == 32'hFFFF_FFFF)
        else $error("denominator reset value wrong");

    AST_DEN_LO_READ: assert property (
        s_rd(sdcr_pkg::OFF_DEN_LO)
        |=> reg_rdata_o == $past(frac_denominator_o[15:0]) ##1 reg_rdata_o == 16'h0000
            || $past(reg_rd_i))
        else $error("denominator low readback wrong");

    AST_SEED_HI: assert property (
        s_wr(sdcr_pkg::OFF_SEED_HI) ##1 !reg_wr_i[*2]
        |-> modulator_seed_o[31:16] == $past(reg_wdata_i, 2))
        else $error("seed high half not held");

    AST_SEED_LO: assert property (
        s_wr(sdcr_pkg::OFF_SEED_LO)
        |=> modulator_seed_o[15:0] == $past(reg_wdata_i)
            && $stable(modulator_seed_o[31:16]))
        else $error("seed low half wrong");

    AST_ORDER_MODE: assert property (
        s_wr(sdcr_pkg::OFF_MOD_CTRL) ##0 (reg_wdata_i[2:0] > 3'h3)
        |=> modulator_mode_o == sdcr_pkg::SDCR_MODE_UNUSED && !integer_mode_o)
        else $error("unused order code not flagged");

    AST_ORDER_INT: assert property (
        s_wr(sdcr_pkg::OFF_MOD_CTRL) ##0 (reg_wdata_i[2:0] == 3'h0)
        |=> integer_mode_o && modulator_mode_o == sdcr_pkg::SDCR_MODE_INTEGER)
        else $error("integer mode not selected");

    AST_DEN_JOIN: assert property (
        s_wr(sdcr_pkg::OFF_DEN_HI) ##1 s_wr(sdcr_pkg::OFF_DEN_LO)
        |=> frac_denominator_o == {$past(reg_wdata_i, 2), $past(reg_wdata_i)})
        else $error("denominator halves joined wrong");

    AST_IDLE_RDATA: assert property (
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside read answer cycle");

endmodule

// ---- tb/sdcr_regs_bench.sv ----
// Self-checking bench for the divider configuration register bank
`timescale 1ns/10ps
module sdcr_regs_bench;
    // ================================================================
    // Signals and design instance
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [sdcr_pkg::ADDR_W-1:0] reg_addr_i = 8'h00;
    logic [sdcr_pkg::DATA_W-1:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [sdcr_pkg::DATA_W-1:0] reg_rdata_o;
    logic first_halver_enable_o;
    logic [sdcr_pkg::FBDIV_W-1:0] feedback_div_o;
    logic [sdcr_pkg::PDD_W-1:0] phase_det_delay_o;
    logic [31:0] frac_denominator_o;
    logic [31:0] modulator_seed_o;
    logic [sdcr_pkg::ORDER_W-1:0] modulator_order_o;
    sdcr_pkg::sdcr_mode_t modulator_mode_o;
    logic integer_mode_o;
    logic reserved_fault_o;
    int fail_count = 0;
    int n_checks = 0;
    // Reset image of words 0x1D to 0x29, in offset order
    logic [15:0] rst_tab [13] = '{16'h318c, 16'h318c, 16'hc3ec, 16'h0393, 16'h1e21,
        16'h0010, 16'h0004, 16'h0070, 16'h0205, 16'hffff, 16'hffff, 16'h0000, 16'h0000};
    // Mandated reserved values; 0x1F keeps the halver on, 0x25 carries delay 0x0A
    logic [7:0] mand_off [8] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h25};
    logic [15:0] mand_tab [8] = '{16'h318c, 16'h318c, 16'h43ec, 16'h0393, 16'h1e21,
        16'h0000, 16'h0004, 16'h8a04};

    always #50 core_clk_i = ~core_clk_i;

    sdcr_regs sdcr_regs_inst (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .first_halver_enable_o(first_halver_enable_o),
        .feedback_div_o(feedback_div_o),
        .phase_det_delay_o(phase_det_delay_o),
        .frac_denominator_o(frac_denominator_o),
        .modulator_seed_o(modulator_seed_o),
        .modulator_order_o(modulator_order_o),
        .modulator_mode_o(modulator_mode_o),
        .integer_mode_o(integer_mode_o),
        .reserved_fault_o(reserved_fault_o)
    );

    // ================================================================
    // Access and compare tasks
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; fields are settled 1 ns after the taking edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    // Two writes on back-to-back strobes, so a split value is joined with no idle cycle
    task automatic wr2(input logic [7:0] a0, input logic [15:0] d0,
        input logic [7:0] a1, input logic [15:0] d1);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a0;
        reg_wdata_i <= d0;
        @(posedge core_clk_i);
        reg_addr_i <= a1;
        reg_wdata_i <= d1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the taking edge
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk_val(32'(reg_rdata_o), 32'(exp));
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ================================================================
    // Test sequence
    initial
    begin
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 13; i++)
            chk_rd(8'h1d + 8'(i), rst_tab[i]);
        chk_rd(8'h2c, 16'h0002);
        chk_val(32'(first_halver_enable_o), 32'h0000_0001);
        chk_val(32'(feedback_div_o), 32'h0000_0070);
        chk_val(32'(phase_det_delay_o), 32'h0000_0002);
        chk_val(frac_denominator_o, 32'hffff_ffff);
        chk_val(modulator_seed_o, 32'h0000_0000);
        chk_val(32'(reserved_fault_o), 32'h0000_0001);
        $display("test reset_values done");

        for (int i = 0; i < 8; i++)
            wr(mand_off[i], mand_tab[i]);
        chk_val(32'(reserved_fault_o), 32'h0000_0000);
        chk_rd(8'h3f, 16'h0000);
        chk_val(32'(phase_det_delay_o), 32'h0000_000a);
        wr(8'h1f, 16'h03ec);
        chk_val(32'(first_halver_enable_o), 32'h0000_0000);
        wr(8'h1f, 16'hc3ec);
        chk_val(32'(first_halver_enable_o), 32'h0000_0001);
        chk_rd(8'h3f, 16'h0004);
        wr(8'h1f, 16'h43ec);
        wr(8'h22, 16'h0008);
        chk_val(32'(reserved_fault_o), 32'h0000_0001);
        chk_rd(8'h3f, 16'h0020);
        wr(8'h1d, 16'h318d);
        wr(8'h20, 16'h0392);
        wr(8'h21, 16'h1e20);
        wr(8'h23, 16'h0005);
        chk_rd(8'h3f, 16'h0079);
        for (int i = 0; i < 8; i++)
            wr(mand_off[i], mand_tab[i]);
        chk_val(32'(reserved_fault_o), 32'h0000_0000);
        $display("test reserved_fields done");

        wr(8'h22, 16'h0007);
        wr(8'h24, 16'hffff);
        chk_val(32'(feedback_div_o), 32'h0007_ffff);
        wr(8'h22, 16'h0005);
        chk_val(32'(feedback_div_o), 32'h0005_ffff);
        wr(8'h24, 16'h1234);
        chk_val(32'(feedback_div_o), 32'h0005_1234);
        chk_rd(8'h24, 16'h1234);
        wr(8'h26, 16'h1234);
        chk_val(frac_denominator_o, 32'h1234_ffff);
        wr(8'h27, 16'habcd);
        chk_val(frac_denominator_o, 32'h1234_abcd);
        chk_rd(8'h26, 16'h1234);
        wr2(8'h26, 16'h5555, 8'h27, 16'haaaa);
        chk_val(frac_denominator_o, 32'h5555_aaaa);
        chk_rd(8'h27, 16'haaaa);
        wr(8'h28, 16'hcafe);
        chk_rd(8'h28, 16'hcafe);
        wr(8'h29, 16'h0001);
        chk_val(modulator_seed_o, 32'hcafe_0001);
        $display("test split_values done");

        for (int o = 0; o < 8; o++)
        begin
            wr(8'h2c, 16'(o));
            chk_val(32'(modulator_order_o), 32'(o));
            chk_val(32'(integer_mode_o), 32'(o == 0));
            chk_val(32'(modulator_mode_o), (o > 3) ? 32'(sdcr_pkg::SDCR_MODE_UNUSED) : 32'(o));
        end
        wr(8'h2c, 16'hffff);
        chk_rd(8'h2c, 16'h0007);
        chk_rd(8'h3f, 16'h2000);
        $display("test modulator_order done");

        // Unmapped offset and the read-only status word ignore writes
        wr(8'h2a, 16'h5a5a);
        chk_rd(8'h2a, 16'h0000);
        wr(8'h3f, 16'h0000);
        chk_rd(8'h3f, 16'h2000);
        @(posedge core_clk_i);
        #1;
        chk_val(32'(reg_rdata_o), 32'h0000_0000);
        $display("test unmapped done");
        stop_test();
    end
endmodule
